// [inc/dbs_link_if.sv]
interface dbs_link_if;
  logic k;
  logic k_n;
  logic c;
  logic c_n;
  logic load_strobe_n;
  logic read_sel;
  logic [dbs_pkg::HI_W-1:0] addr_upper;
  logic burst_addr_bit_high;
  logic burst_addr_bit_low;
  logic [dbs_pkg::DATA_W-1:0] dev_dq_out;
  logic dev_dq_oe_n;
  logic [dbs_pkg::DATA_W-1:0] ctl_dq_out;
  logic ctl_dq_oe_n;
  logic returned_strobe_out;
  logic returned_strobe_out_n;
  logic [dbs_pkg::DATA_W-1:0] dq;

  // shared data pins resolved from the two enables
  assign dq = !dev_dq_oe_n ? dev_dq_out :
              (!ctl_dq_oe_n ? ctl_dq_out : '0);

  modport dev (
    input k, k_n, c, c_n, load_strobe_n, read_sel, addr_upper,
    input burst_addr_bit_high, burst_addr_bit_low, dq,
    output dev_dq_out, dev_dq_oe_n,
    output returned_strobe_out, returned_strobe_out_n
  );
  modport ctl (
    output k, k_n, c, c_n, load_strobe_n, read_sel, addr_upper,
    output burst_addr_bit_high, burst_addr_bit_low,
    output ctl_dq_out, ctl_dq_oe_n,
    input dq, returned_strobe_out, returned_strobe_out_n
  );
endinterface

// [inc/dbs_pkg.sv]
// Overview of operation
// - commands and data sampled on strobe rises only
// - new burst address every other strobe rise
// - write words taken on both strobe rises
// - read words on output clocks, else strobes
// - every transaction moves exactly four words
// - two low address bits load burst counter
// - low load strobe captures address and direction
// - direction high means read, low write
// - eighteen shared address bits, 256K words
// - deselected part ignores all address inputs
// - data pins released whenever no read drives
// - read and write share the data pins
// - inputs and outputs pass through registers
// - echo clocks aligned with read data
// - array writes complete without controller timing
// - strobe up to 250 MHz, slower grades
// - every access begins on true strobe rise
// - echo clocks free running from output clock, else strobes
package dbs_pkg;
  localparam int ADDR_W = 18;
  localparam int HI_W = ADDR_W - 2;
  localparam int DATA_W = 36;
  localparam int DEPTH = 262144;
  localparam logic [2:0] BURST_CNT = 3'h4;
  localparam int FIFO_DEPTH = 2;
  localparam logic [1:0] FIFO_FULL = 2'h2;
  // timing of the strobe that the controller divides from clk
  localparam int CLK_PERIOD_NS = 5;
  localparam int STROBE_PERIOD_NS = 40;
  localparam int MAX_STROBE_MHZ = 250;
  localparam int HALF_CYC = STROBE_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam logic [2:0] PH_LAST = 3'(2 * HALF_CYC - 1);
  localparam logic [2:0] PH_FALL = 3'(HALF_CYC - 1);
  localparam logic [2:0] PH_DAT0 = 3'(HALF_CYC / 2);
  localparam logic [2:0] PH_DAT1 = 3'(HALF_CYC + HALF_CYC / 2);
  // reset levels of the link pins
  localparam logic LOAD_IDLE = 1'b1;
  localparam logic OE_OFF_N = 1'b1;

  // linear advance of the two burst bits
  function automatic logic [1:0] next_lo(input logic [1:0] lo);
    return lo + 2'h1;
  endfunction

  // full word address from upper part and burst bits
  function automatic logic [ADDR_W-1:0] word_addr(
    input logic [HI_W-1:0] hi,
    input logic [1:0] lo
  );
    return {hi, lo};
  endfunction
endpackage

// [rtl/dbs_ctrl.sv]
module dbs_ctrl (
  input wire logic clk,
  input wire logic reset,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic [dbs_pkg::ADDR_W-1:0] req_addr,
  input wire logic [3:0][dbs_pkg::DATA_W-1:0] req_wdata,
  output logic rd_valid,
  output logic [dbs_pkg::DATA_W-1:0] rd_data,
  dbs_link_if.ctl link
);
  logic [2:0] ph_r;
  logic per_r;
  logic k_r;
  logic slot;
  logic accept;
  logic last_rd_r;
  logic wr_on_r;
  logic [3:0][dbs_pkg::DATA_W-1:0] wbuf_r;
  logic ld_n_r;
  logic rsel_r;
  logic [dbs_pkg::ADDR_W-1:0] addr_r;
  logic [dbs_pkg::DATA_W-1:0] dq_r;
  logic oe_n_r;
  logic dat_tick;
  logic [1:0] widx;
  logic [dbs_pkg::DATA_W+1:0] sy1_r;
  logic [dbs_pkg::DATA_W+1:0] sy2_r;
  logic [1:0] echo_prev_r;
  logic echo_edge;
  logic [2:0] rd_left_r;

  // strobe divider: phase counter and period parity
  always_ff @(posedge clk) begin
    if (reset) begin
      ph_r <= '0;
      per_r <= 1'b0;
      k_r <= 1'b0;
    end else begin
      ph_r <= (ph_r == dbs_pkg::PH_LAST) ? 3'h0 : ph_r + 3'h1;
      if (ph_r == dbs_pkg::PH_LAST) begin
        per_r <= ~per_r;
        k_r <= 1'b1;
      end else if (ph_r == dbs_pkg::PH_FALL) begin
        k_r <= 1'b0;
      end
    end
  end

  assign link.k = k_r;
  assign link.k_n = ~k_r;
  assign link.c = k_r;
  assign link.c_n = ~k_r;

  // command slot before every other rise; no write right after a read
  assign slot = per_r & (ph_r == dbs_pkg::PH_DAT1);
  assign req_ready = slot & ~(last_rd_r & ~req_read);
  assign accept = req_ready & req_valid;

  // command pins: load low for one true strobe rise only
  always_ff @(posedge clk) begin
    if (reset) begin
      ld_n_r <= dbs_pkg::LOAD_IDLE;
      rsel_r <= 1'b0;
      addr_r <= '0;
      last_rd_r <= 1'b0;
      wr_on_r <= 1'b0;
      wbuf_r <= '0;
    end else if (slot) begin
      ld_n_r <= ~accept;
      last_rd_r <= accept & req_read;
      wr_on_r <= accept & ~req_read;
      if (accept) begin
        rsel_r <= req_read;
        addr_r <= req_addr;
        wbuf_r <= req_wdata;
      end
    end else if (!per_r && ph_r == dbs_pkg::PH_DAT0) begin
      ld_n_r <= dbs_pkg::LOAD_IDLE;
    end
  end

  assign link.load_strobe_n = ld_n_r;
  assign link.read_sel = rsel_r;
  assign link.addr_upper = addr_r[dbs_pkg::ADDR_W-1:2];
  assign link.burst_addr_bit_high = addr_r[1];
  assign link.burst_addr_bit_low = addr_r[0];

  // write words change one clk cycle before each strobe rise
  assign dat_tick = (ph_r == dbs_pkg::PH_DAT0) | (ph_r == dbs_pkg::PH_DAT1);
  assign widx = {per_r, ph_r == dbs_pkg::PH_DAT1};

  always_ff @(posedge clk) begin
    if (reset) begin
      dq_r <= '0;
      oe_n_r <= dbs_pkg::OE_OFF_N;
    end else if (dat_tick) begin
      if (wr_on_r) begin
        dq_r <= wbuf_r[widx];
        oe_n_r <= 1'b0;
      end else if (widx == 2'h0) begin
        oe_n_r <= dbs_pkg::OE_OFF_N;
      end
    end
  end

  assign link.ctl_dq_out = dq_r;
  assign link.ctl_dq_oe_n = oe_n_r;

  // echo clocks and read data through two flops
  always_ff @(posedge clk) begin
    if (reset) begin
      sy1_r <= '0;
      sy2_r <= '0;
      echo_prev_r <= '0;
    end else begin
      sy1_r <= {link.returned_strobe_out, link.returned_strobe_out_n,
                link.dq};
      sy2_r <= sy1_r;
      echo_prev_r <= sy2_r[dbs_pkg::DATA_W+1:dbs_pkg::DATA_W];
    end
  end

  assign echo_edge = |(sy2_r[dbs_pkg::DATA_W+1:dbs_pkg::DATA_W] &
                       ~echo_prev_r);

  // four read words captured on the echo rises after arming
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_left_r <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else begin
      rd_valid <= 1'b0;
      if (!per_r && ph_r == dbs_pkg::PH_DAT1 && last_rd_r) begin
        rd_left_r <= dbs_pkg::BURST_CNT;
      end else if (echo_edge && rd_left_r != 3'h0) begin
        rd_left_r <= rd_left_r - 3'h1;
        rd_valid <= 1'b1;
        rd_data <= sy2_r[dbs_pkg::DATA_W-1:0];
      end
    end
  end
endmodule

// [rtl/dbs_sram_dev.sv]
module dbs_sram_dev (
  input wire logic clk,
  input wire logic reset,
  input wire logic single_clock_mode,
  output logic burst_active,
  dbs_link_if.dev link
);
  localparam int PIN_W = 6 + dbs_pkg::ADDR_W + dbs_pkg::DATA_W;

  logic [dbs_pkg::DATA_W-1:0] mem [dbs_pkg::DEPTH];
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] sy1_r;
  logic [PIN_W-1:0] sy2_r;
  logic [3:0] clk_prev_r;
  logic k_s;
  logic kn_s;
  logic c_s;
  logic cn_s;
  logic ld_n_s;
  logic rd_s;
  logic [dbs_pkg::HI_W-1:0] hi_s;
  logic a1_s;
  logic a0_s;
  logic [dbs_pkg::DATA_W-1:0] d_s;
  logic k_rise;
  logic kn_rise;
  logic c_rise;
  logic cn_rise;
  logic in_edge;
  logic out_edge;
  logic load_go;
  logic mid_r;
  logic [2:0] wr_left_r;
  logic [dbs_pkg::HI_W-1:0] wr_hi_r;
  logic [1:0] wr_lo_r;
  logic wr_take;
  logic [2:0] pf_left_r;
  logic [dbs_pkg::HI_W-1:0] pf_hi_r;
  logic [1:0] pf_lo_r;
  logic push;
  logic pop;
  logic [dbs_pkg::DATA_W-1:0] fb_mem [dbs_pkg::FIFO_DEPTH];
  logic fb_wr_r;
  logic fb_rd_r;
  logic [1:0] fb_cnt_r;
  logic fb_ready;
  logic fb_valid;
  logic [2:0] out_left_r;
  logic [dbs_pkg::DATA_W-1:0] q_r;
  logic drive_r;
  logic echo_r;
  logic echo_n_r;

  // gather every link pin for the two-flop synchroniser
  assign pins = {link.k, link.k_n, link.c, link.c_n, link.load_strobe_n,
                 link.read_sel, link.addr_upper, link.burst_addr_bit_high,
                 link.burst_addr_bit_low, link.dq};

  // input registers on all synchronous pins
  // no reset, so the idle pin levels are already held at release
  always_ff @(posedge clk) begin
    sy1_r <= pins;
    sy2_r <= sy1_r;
  end

  assign {k_s, kn_s, c_s, cn_s, ld_n_s, rd_s, hi_s, a1_s, a0_s, d_s} = sy2_r;

  // previous levels of the four strobes for edge finding
  always_ff @(posedge clk) begin
    if (reset) begin
      clk_prev_r <= 4'h5; // idle levels: true strobes low, complements high
    end else begin
      clk_prev_r <= {k_s, kn_s, c_s, cn_s};
    end
  end

  // rising edges only; falling edges are never used
  assign k_rise = k_s & ~clk_prev_r[3];
  assign kn_rise = kn_s & ~clk_prev_r[2];
  assign c_rise = c_s & ~clk_prev_r[1];
  assign cn_rise = cn_s & ~clk_prev_r[0];
  assign in_edge = k_rise | kn_rise;
  // output clocks, or the input strobes in single-clock mode
  assign out_edge = single_clock_mode ? (k_rise | kn_rise) :
                    (c_rise | cn_rise);

  // a command starts only on a true strobe rise with load low
  assign load_go = k_rise & ~ld_n_s & ~mid_r;

  // the rise after a load is the burst's middle, never a command
  always_ff @(posedge clk) begin
    if (reset) begin
      mid_r <= 1'b0;
    end else if (k_rise) begin
      mid_r <= load_go;
    end
  end

  // write burst: four words on the strobe rises after the load
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_left_r <= '0;
      wr_hi_r <= '0;
      wr_lo_r <= '0;
    end else if (in_edge) begin
      if (load_go && !rd_s) begin
        wr_left_r <= dbs_pkg::BURST_CNT;
        wr_hi_r <= hi_s;
        wr_lo_r <= {a1_s, a0_s};
      end else if (wr_left_r != 3'h0) begin
        wr_left_r <= wr_left_r - 3'h1;
        wr_lo_r <= dbs_pkg::next_lo(wr_lo_r);
      end
    end
  end

  // a pending burst's last word still lands on a new load edge
  assign wr_take = in_edge & (wr_left_r != 3'h0);

  // self-timed array write, one word per taken strobe
  always_ff @(posedge clk) begin
    if (wr_take) begin
      mem[dbs_pkg::word_addr(wr_hi_r, wr_lo_r)] <= d_s;
    end
  end

  // read prefetch from the array into the output buffer
  assign push = (pf_left_r != 3'h0) & fb_ready;

  always_ff @(posedge clk) begin
    if (reset) begin
      pf_left_r <= '0;
      pf_hi_r <= '0;
      pf_lo_r <= '0;
    end else if (load_go && rd_s) begin
      pf_left_r <= dbs_pkg::BURST_CNT;
      pf_hi_r <= hi_s;
      pf_lo_r <= {a1_s, a0_s};
    end else if (push) begin
      pf_left_r <= pf_left_r - 3'h1;
      pf_lo_r <= dbs_pkg::next_lo(pf_lo_r);
    end
  end

  // two-entry buffer; a full buffer stalls the prefetch
  assign fb_ready = fb_cnt_r != dbs_pkg::FIFO_FULL;
  assign fb_valid = fb_cnt_r != 2'h0;
  assign pop = out_edge & (out_left_r != 3'h0) & fb_valid;

  always_ff @(posedge clk) begin
    if (push) begin
      fb_mem[fb_wr_r] <= mem[dbs_pkg::word_addr(pf_hi_r, pf_lo_r)];
    end
  end

  // buffer pointers and fill level
  always_ff @(posedge clk) begin
    if (reset) begin
      fb_wr_r <= 1'b0;
      fb_rd_r <= 1'b0;
      fb_cnt_r <= '0;
    end else begin
      if (push) begin
        fb_wr_r <= ~fb_wr_r;
      end
      if (pop) begin
        fb_rd_r <= ~fb_rd_r;
      end
      fb_cnt_r <= fb_cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // words still owed to the pins for the current read
  always_ff @(posedge clk) begin
    if (reset) begin
      out_left_r <= '0;
    end else if (load_go && rd_s) begin
      out_left_r <= dbs_pkg::BURST_CNT;
    end else if (pop) begin
      out_left_r <= out_left_r - 3'h1;
    end
  end

  // output register and pin drive, changed on output edges only
  always_ff @(posedge clk) begin
    if (reset) begin
      q_r <= '0;
      drive_r <= 1'b0;
    end else if (out_edge) begin
      if (pop) begin
        q_r <= fb_mem[fb_rd_r];
        drive_r <= 1'b1;
      end else begin
        drive_r <= 1'b0;
      end
    end
  end

  assign link.dev_dq_out = q_r;
  assign link.dev_dq_oe_n = ~drive_r;

  // free-running echo clocks, same register stage as data
  always_ff @(posedge clk) begin
    if (reset) begin
      echo_r <= 1'b0;
      echo_n_r <= 1'b0;
    end else begin
      echo_r <= single_clock_mode ? k_s : c_s;
      echo_n_r <= single_clock_mode ? kn_s : cn_s;
    end
  end

  assign link.returned_strobe_out = echo_r;
  assign link.returned_strobe_out_n = echo_n_r;

  // any burst still moving words
  assign burst_active = (wr_left_r != 3'h0) | (out_left_r != 3'h0);
endmodule

// [verification/dbs_link_assertions.sv]
module dbs_link_assertions (
  input wire logic clk,
  input wire logic reset,
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic load_strobe_n,
  input wire logic read_sel,
  input wire logic [dbs_pkg::DATA_W-1:0] dev_dq_out,
  input wire logic dev_dq_oe_n,
  input wire logic [dbs_pkg::DATA_W-1:0] ctl_dq_out,
  input wire logic ctl_dq_oe_n,
  input wire logic returned_strobe_out,
  input wire logic returned_strobe_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic k_q_r;
  logic last_load_r;
  logic [5:0] since_rd_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // strobe history: was the previous rise a load
  always_ff @(posedge clk) begin
    if (reset) begin
      k_q_r <= 1'b0;
      last_load_r <= 1'b0;
    end else begin
      k_q_r <= k;
      if (k && !k_q_r) last_load_r <= !load_strobe_n;
    end
  end

  // cycles since the last read load, saturating
  always_ff @(posedge clk) begin
    if (reset) since_rd_r <= 6'h3f;
    else if (k && !k_q_r && !load_strobe_n && read_sel) since_rd_r <= 6'h00;
    else if (since_rd_r != 6'h3f) since_rd_r <= since_rd_r + 6'h01;
  end

  strobe_pair_a: assert property (k_n == !k)
    else $error("input strobes not complementary");
  bus_fight_a: assert property (dev_dq_oe_n || ctl_dq_oe_n)
    else $error("both ends drive the data pins");
  cmd_hold_a: assert property ($rose(k) |=>
    ($stable(load_strobe_n) && $stable(read_sel))[*2])
    else $error("command moved right after strobe rise");
  wdata_hold_a: assert property (($rose(k) || $rose(k_n))
    && !ctl_dq_oe_n |=> $stable(ctl_dq_out)[*2])
    else $error("write word moved right after strobe rise");
  load_space_a: assert property ($rose(k) && !load_strobe_n
    |-> !last_load_r)
    else $error("loads on adjacent strobe rises");
  read_start_a: assert property ($rose(k) && !load_strobe_n
    && read_sel |-> ##[3:12] !dev_dq_oe_n)
    else $error("read load drove no data");
  write_quiet_a: assert property ($rose(k) && !load_strobe_n
    && !read_sel |-> dev_dq_oe_n[*8])
    else $error("device drove pins during a write");
  read_only_a: assert property (!dev_dq_oe_n |-> since_rd_r < 6'h30)
    else $error("device drove pins with no read");
  echo_rise_a: assert property ($rose(c) |->
    ##[1:4] returned_strobe_out)
    else $error("echo did not follow output clock rise");
  echo_fall_a: assert property ($fell(c) |->
    ##[1:4] !returned_strobe_out)
    else $error("echo did not follow output clock fall");
  data_echo_a: assert property (!$past(dev_dq_oe_n) && !dev_dq_oe_n
    && $changed(dev_dq_out) |-> $changed(returned_strobe_out)
    || $changed(returned_strobe_out_n))
    else $error("read word changed without an echo edge");
endmodule

// [verification/ddr_burst4_sram_port_bench.sv]
module ddr_burst4_sram_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic single_clock_mode;
  logic burst_active;
  logic req_valid;
  logic req_ready;
  logic req_read;
  logic [dbs_pkg::ADDR_W-1:0] req_addr;
  logic [3:0][dbs_pkg::DATA_W-1:0] req_wdata;
  logic rd_valid;
  logic [dbs_pkg::DATA_W-1:0] rd_data;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int seed = 32'hf2e82420;
  logic [dbs_pkg::DATA_W-1:0] mem [int];
  logic [dbs_pkg::DATA_W-1:0] exp_q [$];
  logic [15:0] written [$];
  int last_acc = -1;
  logic last_rd = 1'b0;
  localparam int SLOT_CYC = 4 * dbs_pkg::HALF_CYC;

  dbs_link_if link_i ();

  dbs_sram_dev dbs_sram_dev_inst (.clk(clk), .reset(reset),
    .single_clock_mode(single_clock_mode), .burst_active(burst_active),
    .link(link_i));
  dbs_ctrl dbs_ctrl_inst (.clk(clk), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req_read(req_read), .req_addr(req_addr),
    .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
    .link(link_i));
  dbs_link_assertions dbs_link_assertions_inst (.clk(clk), .reset(reset),
    .k(link_i.k), .k_n(link_i.k_n), .c(link_i.c),
    .load_strobe_n(link_i.load_strobe_n), .read_sel(link_i.read_sel),
    .dev_dq_out(link_i.dev_dq_out), .dev_dq_oe_n(link_i.dev_dq_oe_n),
    .ctl_dq_out(link_i.ctl_dq_out), .ctl_dq_oe_n(link_i.ctl_dq_oe_n),
    .returned_strobe_out(link_i.returned_strobe_out),
    .returned_strobe_out_n(link_i.returned_strobe_out_n));

  // 200 MHz system clock
  always #2.5 clk = ~clk;

  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check_word(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_gap(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      n_errors++;
      $display("unexpected gap at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // offer one command, model it when the controller takes it
  task automatic issue(input logic rd, input logic [17:0] addr,
                       input logic [3:0][35:0] wd);
    int n;
    int exp_gap;
    n = 0;
    req_valid <= 1'b1;
    req_read <= rd;
    req_addr <= addr;
    req_wdata <= wd;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    if (n >= 200) n_errors++;
    // one command per two strobe periods, a write after a read one later
    if (last_acc >= 0) begin
      exp_gap = (last_rd && !rd) ? 2 * SLOT_CYC : SLOT_CYC;
      check_gap(cycles - last_acc, exp_gap);
    end
    last_acc = cycles;
    last_rd = rd;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      if (rd) exp_q.push_back(mem[{addr[17:2], 2'(addr[1:0] + 2'(i))}]);
      else mem[{addr[17:2], 2'(addr[1:0] + 2'(i))}] = wd[i];
    end
  endtask

  // stop offering, wait for all read words and the burst to end
  task automatic drain();
    int n;
    n = 0;
    req_valid <= 1'b0;
    while ((exp_q.size() != 0 || burst_active !== 1'b0) && n < 400) begin
      @(negedge clk);
      n++;
    end
    repeat (32) @(negedge clk);
    check_bit(burst_active, 1'b0);
    check_bit(exp_q.size() == 0, 1'b1);
    last_acc = -1;
    @(posedge clk);
  endtask

  // read words compared in burst order against the model
  always @(negedge clk) begin
    if (!reset && rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check_bit(rd_valid, 1'b0);
      else check_word(rd_data, exp_q.pop_front());
    end
  end

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      results();
    end
  end

  initial begin
    logic [3:0][35:0] wd;
    logic [15:0] hi;
    single_clock_mode = 1'b0;
    req_valid = 1'b0;
    req_read = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    for (int pass = 0; pass < 2; pass++) begin
      single_clock_mode <= pass[0];
      // writes at every start offset, top group included
      for (int i = 0; i < 8; i++) begin
        hi = (i == 0) ? 16'hffff : 16'(pass * 8 + i);
        for (int j = 0; j < 4; j++) begin
          wd[j] = 36'({$random(seed), $random(seed)});
        end
        written.push_back(hi);
        issue(1'b0, {hi, 2'(i)}, wd);
      end
      // back-to-back reads from random groups and offsets
      for (int i = 0; i < 8; i++) begin
        hi = written[($unsigned($random(seed))) % written.size()];
        issue(1'b1, {hi, 2'($random(seed))}, wd);
      end
      // write straight after a read, then read it back
      for (int j = 0; j < 4; j++) wd[j] = 36'({$random(seed), $random(seed)});
      issue(1'b0, {written[1], 2'h3}, wd);
      issue(1'b1, {written[1], 2'h1}, wd);
      drain();
    end
    results();
  end
endmodule
